// ### core/dac_core_mode_and_clock_trim.sv
// Purpose: sample formatting and clock trim registers for a quad-switch core
// Assumes: serial port pins are synchronous to core_clk and slow (>=4 clk)
// Notes:   one core_clk cycle stands for one half period of the dac clock
//
// Functional notes
// - one switch pair per half period, alternating
// - two switches transition every half period
// - mode field: 00 nrz, 10 rz, 01 chop
// - rz: data rising, zero falling
// - chop: data rising, complement falling
// - nrz: same sample on both edges
// - interpolator produces the falling edge sample, nrz only
// - three clock registers reachable from 0x082
// - duty bit 7 enables correction
// - bit 6 applies offset, bits 4:0 offset
// - offset sign bit 4, magnitude bits 3:0
// - phase trim adds 20 fF steps
// - trim sign picks leg, 100000 none
// - shuffle control bit 2 enables shuffle
// - shuffle only msb segments
`timescale 1ns/1ns

module dac_core_mode_and_clock_trim
  import dac_core_pkg::*;
#(
  parameter int WIDTH = dac_core_pkg::SAMPLE_WIDTH,
  parameter int DEPTH = dac_core_pkg::FIFO_DEPTH,
  parameter int MSBS  = dac_core_pkg::SHUF_MSBS
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_cs_b,
  input  wire logic                  spi_sdi,
  output logic                       spi_sdo,
  output logic                       spi_sdo_oe,
  input  wire logic [WIDTH-1:0]      sample_data,
  input  wire logic                  sample_valid,
  output logic                       sample_ready,
  output logic      [WIDTH-1:0]      core_word,
  output logic                       pair_a_en,
  output logic                       pair_b_en,
  output logic      [(1<<MSBS)-2:0]  core_msb_segments,
  output logic      [WIDTH-MSBS-1:0] core_lsb_bits,
  output logic                       dcc_en,
  output logic                       duty_ofs_en,
  output logic                       duty_ofs_neg,
  output logic      [3:0]            duty_ofs_mag,
  output logic      [4:0]            trim_pos_steps,
  output logic      [4:0]            trim_neg_steps
);

  import dac_core_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************

  // steps for one clock leg from a sign-magnitude trim code
  function automatic logic [4:0] leg_steps(input logic [5:0] code,
                                           input logic       neg_leg);
    leg_steps = (code[TRIM_SIGN_BIT] == neg_leg) ? code[4:0] : 5'h00;
  endfunction

  // ************************************************************
  // declarations
  // ************************************************************
  spi_state_t  spi_state;       // serial frame state
  spi_state_t  next_spi_state;  // serial frame next state
  logic        sclk_q;          // previous serial clock level
  logic        sclk_rise;       // serial clock rising
  logic        sclk_fall;       // serial clock falling
  logic [3:0]  bit_cnt;         // bit within phase
  logic [15:0] instr;           // instruction shift
  logic [15:0] next_instr;      // instruction with new bit
  logic [7:0]  wdata_sh;        // write data shift
  logic [7:0]  rdata_sh;        // read data shift
  logic [7:0]  rd_value;        // selected register value
  logic        is_read;         // frame is a read
  logic        wr_en;           // register write strobe
  logic [14:0] wr_addr;         // register write address
  logic [7:0]  wr_data;         // register write data

  logic [7:0]  phase_trim;      // clock phase trim
  logic [7:0]  duty_ctrl;       // clock duty control
  logic [7:0]  clk_aux1;        // second clock word
  logic [7:0]  clk_aux2;        // third clock word
  logic [7:0]  shuffle_ctrl;    // shuffle control
  logic [7:0]  out_mode_sel;    // output mode select
  logic [7:0]  interp_ctrl;     // interpolation control
  logic        underrun;        // sticky buffer underrun

  logic [WIDTH-1:0] fifo_data;  // buffer head
  logic             fifo_valid; // buffer has data
  logic             fifo_pop;   // take a sample
  logic             fall_half;  // 1 = falling half period
  logic [WIDTH-1:0] held;       // sample of this period
  logic [WIDTH-1:0] prev;       // sample of last period
  logic [WIDTH-1:0] next_core_word; // word for next half
  out_mode_t        mode;       // effective mode
  logic             interp_on;  // interpolation enabled
  logic [WIDTH:0]   avg_sum;    // interpolation sum

  // ************************************************************
  // serial configuration port
  // ************************************************************
  assign sclk_rise  = spi_sclk && !sclk_q;
  assign sclk_fall  = !spi_sclk && sclk_q;
  assign next_instr = {instr[14:0], spi_sdi};
  assign is_read    = instr[15];
  assign wr_addr    = instr[14:0];
  assign wr_data    = {wdata_sh[6:0], spi_sdi};
  assign wr_en      = (spi_state == SPI_DATA) && sclk_rise
                      && (bit_cnt == SPI_DATA_LAST) && !is_read;
  assign spi_sdo    = rdata_sh[7];
  assign spi_sdo_oe = (spi_state == SPI_DATA) && is_read && !spi_cs_b;

  // serial clock edge memory
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk;
    end
  end

  // frame state sequencing
  always_comb begin
    next_spi_state = spi_state;
    if (spi_cs_b) begin
      next_spi_state = SPI_IDLE;
    end else begin
      case (spi_state)
        SPI_IDLE: begin
          next_spi_state = SPI_INSTR;
        end
        SPI_INSTR: begin
          if (sclk_rise && bit_cnt == SPI_INSTR_LAST) begin
            next_spi_state = SPI_DATA;
          end
        end
        SPI_DATA: begin
          if (sclk_rise && bit_cnt == SPI_DATA_LAST) begin
            next_spi_state = SPI_DONE;
          end
        end
        default: begin
          next_spi_state = SPI_DONE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_state <= SPI_IDLE;
    end else begin
      spi_state <= next_spi_state;
    end
  end

  // bit counting and shifting
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt  <= 4'h0;
      instr    <= 16'h0000;
      wdata_sh <= 8'h00;
    end else if (spi_state == SPI_IDLE) begin
      bit_cnt <= 4'h0;
    end else if (sclk_rise) begin
      if (spi_state == SPI_INSTR) begin
        instr   <= next_instr;
        bit_cnt <= (bit_cnt == SPI_INSTR_LAST) ? 4'h0 : bit_cnt + 4'h1;
      end else if (spi_state == SPI_DATA) begin
        wdata_sh <= wr_data;
        bit_cnt  <= bit_cnt + 4'h1;
      end
    end
  end

  // read value select, unmapped reads as zero
  always_comb begin
    rd_value = 8'h00;
    if (next_instr[14:0] == ADDR_PHASE_TRIM) begin
      rd_value = phase_trim;
    end else if (next_instr[14:0] == ADDR_DUTY_CTRL) begin
      rd_value = duty_ctrl;
    end else if (next_instr[14:0] == ADDR_CLK_AUX1) begin
      rd_value = clk_aux1;
    end else if (next_instr[14:0] == ADDR_CLK_AUX2) begin
      rd_value = clk_aux2;
    end else if (next_instr[14:0] == ADDR_SHUFFLE) begin
      rd_value = shuffle_ctrl;
    end else if (next_instr[14:0] == ADDR_OUT_MODE) begin
      rd_value = out_mode_sel;
    end else if (next_instr[14:0] == ADDR_INTERP) begin
      rd_value = interp_ctrl;
    end else if (next_instr[14:0] == ADDR_STATUS) begin
      rd_value = {4'h0, fall_half, !sample_ready, !fifo_valid, underrun};
    end
  end

  // read data out, loaded at the last address bit
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_sh <= 8'h00;
    end else if (spi_state == SPI_INSTR && sclk_rise
                 && bit_cnt == SPI_INSTR_LAST) begin
      rdata_sh <= rd_value;
    end else if (spi_state == SPI_DATA && sclk_fall && bit_cnt != 4'h0) begin
      rdata_sh <= {rdata_sh[6:0], 1'b0};
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************

  // clock control group
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_trim <= RST_PHASE_TRIM;
      duty_ctrl  <= RST_DUTY_CTRL;
      clk_aux1   <= RST_CLK_AUX;
      clk_aux2   <= RST_CLK_AUX;
    end else if (wr_en) begin
      if (wr_addr == ADDR_PHASE_TRIM) begin
        phase_trim <= wr_data;
      end else if (wr_addr == ADDR_DUTY_CTRL) begin
        duty_ctrl <= wr_data;
      end else if (wr_addr == ADDR_CLK_AUX1) begin
        clk_aux1 <= wr_data;
      end else if (wr_addr == ADDR_CLK_AUX2) begin
        clk_aux2 <= wr_data;
      end
    end
  end

  // datapath control group
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shuffle_ctrl <= RST_SHUFFLE;
      out_mode_sel <= RST_OUT_MODE;
      interp_ctrl  <= RST_INTERP;
    end else if (wr_en) begin
      if (wr_addr == ADDR_SHUFFLE) begin
        shuffle_ctrl <= wr_data;
      end else if (wr_addr == ADDR_OUT_MODE) begin
        out_mode_sel <= wr_data;
      end else if (wr_addr == ADDR_INTERP) begin
        interp_ctrl <= wr_data;
      end
    end
  end

  // sticky underrun, a new underrun beats a clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      underrun <= 1'b0;
    end else if (!fall_half && !fifo_valid) begin
      underrun <= 1'b1;
    end else if (wr_en && wr_addr == ADDR_STATUS
                 && wr_data[STAT_UNDER_BIT]) begin
      underrun <= 1'b0;
    end
  end

  // ************************************************************
  // clock trim outputs
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dcc_en         <= 1'b0;
      duty_ofs_en    <= 1'b0;
      duty_ofs_neg   <= 1'b0;
      duty_ofs_mag   <= 4'h0;
      trim_pos_steps <= 5'h00;
      trim_neg_steps <= 5'h00;
    end else begin
      dcc_en         <= duty_ctrl[DUTY_DCC_BIT];
      duty_ofs_en    <= duty_ctrl[DUTY_OFS_EN_BIT];
      duty_ofs_neg   <= duty_ctrl[DUTY_SIGN_BIT];
      duty_ofs_mag   <= duty_ctrl[3:0];
      trim_pos_steps <= leg_steps(phase_trim[5:0], 1'b0);
      trim_neg_steps <= leg_steps(phase_trim[5:0], 1'b1);
    end
  end

  // ************************************************************
  // sample buffer
  // ************************************************************
  assign fifo_pop = !fall_half && fifo_valid;

  sample_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (!fall_half)
  );

  // ************************************************************
  // half period formatting
  // ************************************************************

  // reserved code folds onto nrz
  always_comb begin
    case (out_mode_sel[1:0])
      MODE_CHOP: mode = MODE_CHOP;
      MODE_RZ:   mode = MODE_RZ;
      default:   mode = MODE_NRZ;
    endcase
    interp_on = interp_ctrl[INTERP_EN_BIT];
  end

  // half period tracker, low = rising edge half
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fall_half <= 1'b0;
    end else begin
      fall_half <= !fall_half;
    end
  end

  // current and previous period samples, held on underrun
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      held <= '0;
      prev <= '0;
    end else if (fifo_pop) begin
      held <= fifo_data;
      prev <= held;
    end
  end

  // word chosen for the coming half period
  always_comb begin
    avg_sum        = {1'b0, held} + {1'b0, prev};
    next_core_word = held;
    if (!fall_half) begin
      next_core_word = fifo_valid ? fifo_data : held;
    end else begin
      case (mode)
        MODE_RZ: begin
          next_core_word = '0;
        end
        MODE_CHOP: begin
          next_core_word = ~held;
        end
        default: begin
          if (interp_on) begin
            next_core_word = avg_sum[WIDTH:1];
          end else begin
            next_core_word = held;
          end
        end
      endcase
    end
  end

  // core word and switch pair enables
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_word <= '0;
      pair_a_en <= 1'b0;
      pair_b_en <= 1'b0;
    end else begin
      core_word <= next_core_word;
      pair_a_en <= !fall_half;
      pair_b_en <= fall_half;
    end
  end

  // ************************************************************
  // msb segment shuffle
  // ************************************************************
  segment_shuffler #(
    .WIDTH (WIDTH),
    .MSBS  (MSBS)
  ) u_shuffle (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .shuffle_en   (shuffle_ctrl[SHUFFLE_EN_BIT]),
    .word         (next_core_word),
    .msb_segments (core_msb_segments),
    .lsb_bits     (core_lsb_bits)
  );

endmodule

// ### core/dac_core_pkg.sv
// Purpose: shared constants and types for the dac core mode and clock trim
// Assumes: byte-wide registers on a 15-bit configuration address space
// Notes:   all offsets, field positions and reset values live here

package dac_core_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [14:0] ADDR_PHASE_TRIM = 15'h007f; // clock phase trim
  localparam logic [14:0] ADDR_DUTY_CTRL  = 15'h0082; // clock duty control
  localparam logic [14:0] ADDR_CLK_AUX1   = 15'h0083; // clock control word 2
  localparam logic [14:0] ADDR_CLK_AUX2   = 15'h0084; // clock control word 3
  localparam logic [14:0] ADDR_SHUFFLE    = 15'h0151; // shuffle control
  localparam logic [14:0] ADDR_OUT_MODE   = 15'h0152; // output mode select
  localparam logic [14:0] ADDR_INTERP     = 15'h0153; // interpolation control
  localparam logic [14:0] ADDR_STATUS     = 15'h0154; // datapath status

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_PHASE_TRIM = 8'h00;
  localparam logic [7:0] RST_DUTY_CTRL  = 8'h00;
  localparam logic [7:0] RST_CLK_AUX    = 8'h00;
  localparam logic [7:0] RST_SHUFFLE    = 8'h00;
  localparam logic [7:0] RST_OUT_MODE   = 8'h00;
  localparam logic [7:0] RST_INTERP     = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int DUTY_DCC_BIT    = 7; // duty-cycle correction enable
  localparam int DUTY_OFS_EN_BIT = 6; // duty offset apply enable
  localparam int DUTY_SIGN_BIT   = 4; // duty offset sign, 1 = negative
  localparam int TRIM_SIGN_BIT   = 5; // phase trim sign, 1 = negative leg
  localparam int SHUFFLE_EN_BIT  = 2; // shuffle enable
  localparam int INTERP_EN_BIT   = 0; // two-times interpolation enable
  localparam int STAT_UNDER_BIT  = 0; // sticky underrun, write 1 to clear
  localparam int STAT_EMPTY_BIT  = 1; // buffer empty
  localparam int STAT_FULL_BIT   = 2; // buffer full
  localparam int STAT_PHASE_BIT  = 3; // current half period, 1 = falling

  // ************************************************************
  // serial port framing and sizes
  // ************************************************************
  localparam logic [3:0] SPI_INSTR_LAST = 4'hf; // 16 instruction bits
  localparam logic [3:0] SPI_DATA_LAST  = 4'h7; // 8 data bits
  localparam int         SAMPLE_WIDTH   = 16;   // converter sample width
  localparam int         FIFO_DEPTH     = 4;    // sample buffer depth
  localparam int         SHUF_MSBS      = 4;    // shuffled msb count

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_NRZ  = 2'h0,
    MODE_CHOP = 2'h1,
    MODE_RZ   = 2'h2,
    MODE_RSVD = 2'h3
  } out_mode_t;

  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b00,
    SPI_INSTR = 2'b01,
    SPI_DATA  = 2'b11,
    SPI_DONE  = 2'b10
  } spi_state_t;

endpackage

// ### core/sample_fifo.sv
// Purpose: small sample buffer with valid and ready on both sides
// Assumes: single clock, depth is a power of two
// Notes:   full and empty are exact; writer stalls on full
`timescale 1ns/1ns

module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [AW-1:0]    wr_ptr;        // next write slot
  logic [AW-1:0]    rd_ptr;        // next read slot
  logic [AW:0]      count;         // words held
  logic             push;          // accepted write
  logic             pop;           // accepted read

  // ************************************************************
  // handshakes
  // ************************************************************
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end

endmodule

// ### core/segment_shuffler.sv
// Purpose: msb thermometer decode with optional random segment rotation
// Assumes: word arrives in the same cycle it should be registered
// Notes:   low bits pass straight through, one register stage
`timescale 1ns/1ns

module segment_shuffler #(
  parameter int WIDTH = 16,
  parameter int MSBS  = 4
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic                   shuffle_en,
  input  wire logic [WIDTH-1:0]       word,
  output logic      [(1<<MSBS)-2:0]   msb_segments,
  output logic      [WIDTH-MSBS-1:0]  lsb_bits
);

  localparam int SEGS = (1 << MSBS) - 1;

  logic [15:0]       lfsr;      // pseudo random source
  logic [SEGS-1:0]   therm;     // unrotated segment code
  logic [2*SEGS-1:0] doubled;   // two copies for rotation
  logic [MSBS-1:0]   rot;       // rotation amount

  // ************************************************************
  // decode and rotate
  // ************************************************************
  always_comb begin
    for (int i = 0; i < SEGS; i++) begin
      therm[i] = (32'(word[WIDTH-1 -: MSBS]) > i);
    end
    doubled = {therm, therm};
    rot     = shuffle_en ? lfsr[MSBS-1:0] : '0;
  end

  // random sequence, free running
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsr <= 16'h0001;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // output register, only msb segments move
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      msb_segments <= '0;
      lsb_bits     <= '0;
    end else begin
      msb_segments <= SEGS'(doubled >> rot);
      lsb_bits     <= word[WIDTH-MSBS-1:0];
    end
  end

endmodule

// ### bench/dac_props.sv
// Purpose: port assertions for the dac core block
// Assumes: one clock domain, reset active low
// Notes:   bound to every instance of the top module
`timescale 1ns/1ns
module dac_props #(
  parameter int WIDTH = 16,
  parameter int MSBS  = 4
) (
  input wire logic                  core_clk,
  input wire logic                  rst_b,
  input wire logic                  spi_cs_b,
  input wire logic                  spi_sdo_oe,
  input wire logic [WIDTH-1:0]      core_word,
  input wire logic                  pair_a_en,
  input wire logic                  pair_b_en,
  input wire logic [(1<<MSBS)-2:0]  core_msb_segments,
  input wire logic [WIDTH-MSBS-1:0] core_lsb_bits,
  input wire logic                  dcc_en,
  input wire logic [3:0]            duty_ofs_mag,
  input wire logic [4:0]            trim_pos_steps,
  input wire logic [4:0]            trim_neg_steps
);
  // ********
  // relations
  // ********
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  pair_excl_a: assert property (!(pair_a_en && pair_b_en))
    else $error("both pairs on");
  pair_next_a: assert property (pair_a_en |=> pair_b_en)
    else $error("falling pair missing");
  pair_back_a: assert property (pair_b_en |=> pair_a_en)
    else $error("rising pair missing");
  lsb_pass_a: assert property (
    core_lsb_bits == core_word[WIDTH-MSBS-1:0]) else $error("lsb altered");
  seg_count_a: assert property (
    $countones(core_msb_segments) == core_word[WIDTH-1:WIDTH-MSBS])
    else $error("segment count wrong");
  sdo_idle_a: assert property (spi_cs_b |-> !spi_sdo_oe)
    else $error("sdo driven idle");
  duty_hold_a: assert property (spi_cs_b && $past(spi_cs_b)
    |-> $stable({dcc_en, duty_ofs_mag})) else $error("duty moved");
  trim_leg_a: assert property (
    trim_pos_steps == 0 || trim_neg_steps == 0)
    else $error("trim on both legs");
  trim_hold_a: assert property (spi_cs_b && $past(spi_cs_b)
    |-> $stable({trim_pos_steps, trim_neg_steps})) else $error("trim moved");
endmodule
bind dac_core_mode_and_clock_trim dac_props #(.WIDTH(WIDTH), .MSBS(MSBS))
  i_props (.core_clk, .rst_b, .spi_cs_b, .spi_sdo_oe, .core_word, .pair_a_en,
  .pair_b_en, .core_msb_segments, .core_lsb_bits, .dcc_en, .duty_ofs_mag,
  .trim_pos_steps, .trim_neg_steps);

// ### bench/spi_host_model.sv
// Purpose: host driving the serial configuration port
// Assumes: sclk idles low, each level two core clocks
// Notes:   sdi is inverted after a frame so stale bits never pass
`timescale 1ns/1ns
module spi_host_model #(
  parameter logic [7:0] DLL_VAL = 8'h00 // start-up setting
) (
  input  wire logic core_clk,
  output logic      spi_sclk,
  output logic      spi_cs_b,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  // ********
  // frames
  // ********
  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_sdi  = 1'b0;
  end
  // one 24-bit frame, msb first; q gets read data
  task automatic xfer(input logic r, input logic [14:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {r, a, d};
    q = 8'h00;
    @(posedge core_clk) #1 spi_cs_b = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = f[i];
      repeat (2) @(posedge core_clk);
      #1 spi_sclk = 1'b1;
      if (i < 8) q[i] = spi_sdo;
      repeat (2) @(posedge core_clk);
      #1 spi_sclk = 1'b0;
    end
    repeat (4) @(posedge core_clk);
    #1 spi_cs_b = 1'b1;
    spi_sdi = ~spi_sdi;
    repeat (3) @(posedge core_clk);
  endtask
  // clock lock loop start-up write
  task automatic dll_start(output logic [7:0] q);
    xfer(1'b0, 15'h0090, DLL_VAL, q);
  endtask
endmodule

// ### bench/tb_dac_core_mode_and_clock_trim.sv
// Purpose: self-checking bench for the dac core block
// Assumes: host model on the serial port, 25 MHz clock
// Notes:   each scenario is one task
`timescale 1ns/1ns
module tb_dac_core_mode_and_clock_trim;
  import dac_core_pkg::*;
  logic        core_clk = 1'b0, rst_b = 1'b0, sample_valid = 1'b0;
  logic [15:0] sample_data = 16'h0000, core_word;
  logic        spi_sclk, spi_cs_b, spi_sdi, spi_sdo, spi_sdo_oe;
  logic        sample_ready, pair_a_en, pair_b_en, dcc_en;
  logic        duty_ofs_en, duty_ofs_neg;
  logic [14:0] core_msb_segments;
  logic [11:0] core_lsb_bits;
  logic [3:0]  duty_ofs_mag;
  logic [4:0]  trim_pos_steps, trim_neg_steps;
  logic [7:0]  q;
  int          n_fail = 0, num_checks = 0, cyc = 0;
  // ********
  // clock, parts
  // ********
  always #20 core_clk = ~core_clk;
  dac_core_mode_and_clock_trim i_dut (.core_clk, .rst_b, .spi_sclk,
    .spi_cs_b, .spi_sdi, .spi_sdo, .spi_sdo_oe, .sample_data, .sample_valid,
    .sample_ready, .core_word, .pair_a_en, .pair_b_en, .core_msb_segments,
    .core_lsb_bits, .dcc_en, .duty_ofs_en, .duty_ofs_neg, .duty_ofs_mag,
    .trim_pos_steps, .trim_neg_steps);
  spi_host_model i_host (.core_clk, .spi_sclk, .spi_cs_b, .spi_sdi,
    .spi_sdo);
  // ********
  // helpers
  // ********
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    i_host.xfer(1'b1, a, 8'h00, q);
    chk(16'(q), 16'(e));
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end
  // ********
  // scenarios
  // ********
  task automatic t_regs;
    logic [14:0] ra[5] = '{ADDR_PHASE_TRIM, ADDR_DUTY_CTRL, ADDR_CLK_AUX1,
                           ADDR_SHUFFLE, ADDR_OUT_MODE};
    foreach (ra[i]) rd(ra[i], 8'h00);
    wr(ADDR_CLK_AUX2, 8'ha5);
    rd(ADDR_CLK_AUX2, 8'ha5);
    i_host.dll_start(q);
    rd(15'h0090, 8'h00);
  endtask
  task automatic t_duty;
    wr(ADDR_DUTY_CTRL, 8'hd5);
    chk(16'({dcc_en, duty_ofs_en, duty_ofs_neg, duty_ofs_mag}), 16'h0075);
    wr(ADDR_DUTY_CTRL, 8'h4a);
    chk(16'({dcc_en, duty_ofs_en, duty_ofs_neg, duty_ofs_mag}), 16'h002a);
    rd(ADDR_DUTY_CTRL, 8'h4a);
  endtask
  task automatic t_trim;
    logic [7:0] tv[4] = '{8'h05, 8'h23, 8'h20, 8'h3f};
    foreach (tv[i]) begin
      wr(ADDR_PHASE_TRIM, tv[i]);
      chk(16'({trim_pos_steps, trim_neg_steps}), tv[i][5] ?
          16'(tv[i][4:0]) : 16'({tv[i][4:0], 5'h00}));
    end
  endtask
  task automatic t_mode;
    logic [15:0] d, e;
    for (int m = 0; m < 5; m++) begin
      wr(ADDR_INTERP, 8'(m / 4));
      wr(ADDR_OUT_MODE, 8'(m % 4));
      d = {4'(m) + 4'h9, 12'h5a3};
      @(posedge core_clk) #1 sample_valid = 1'b1;
      sample_data = d;
      @(posedge core_clk) #1 sample_valid = 1'b0;
      for (int k = 0; k < 12 && !(pair_a_en === 1'b1 && core_word === d);
           k++) @(posedge core_clk) #1;
      chk(core_word, d);
      @(posedge core_clk) #1;
      // m 4: mean of d5a3 and the previous sample c5a3
      e = m == 1 ? ~d : m == 2 ? 16'h0000 : m == 4 ? 16'hcda3 : d;
      chk(core_word, e);
      chk(16'(pair_b_en), 16'h0001);
    end
  endtask
  task automatic t_fifo;
    wr(ADDR_SHUFFLE, 8'h04);
    @(posedge core_clk) #1 sample_valid = 1'b1;
    for (int k = 0; k < 12 && sample_ready !== 1'b0; k++) begin
      sample_data = {4'(k + 3), 12'h0f0};
      @(posedge core_clk) #1;
    end
    chk(16'(sample_ready), 16'h0000);
    sample_valid = 1'b0;
    repeat (12) @(posedge core_clk);
    chk(16'(sample_ready), 16'h0001);
    rd(ADDR_SHUFFLE, 8'h04);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rst_b = 1'b1;
    t_regs;
    t_duty;
    t_trim;
    t_mode;
    t_fifo;
    stop_test;
  end
endmodule
